// *** inc/ncai_pkg.sv ***
// package for the nand command/address host controller
// assumes a 10 MHz system clock and a device without a clock of its own
package ncai_pkg;
  //----------------------------------------------------------------
  // clock and timing
  //----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int T_WB_NS = 500; // wait before busy is trusted
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_LOW_CYC = 4; // read strobe low, covers the pin synchroniser
  //----------------------------------------------------------------
  // command codes
  //----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_LO = 8'h00;
  localparam logic [7:0] CMD_READ_HI = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_COPY = 8'h00;
  localparam logic [7:0] CMD_COPY_GO = 8'h8A;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  //----------------------------------------------------------------
  // geometry
  //----------------------------------------------------------------
  localparam int PAGES = 65536;
  localparam int PAGES_PER_BLK = 32;
  localparam int BLOCKS = PAGES / PAGES_PER_BLK;
  localparam int PAGE_X8 = 528;
  localparam int PAGE_X16 = 264;
  localparam int ROW_W = 16;
  localparam int COL_W = 10;
  localparam int LEN_W = 10;
  localparam logic [COL_W-1:0] SPARE_X8 = 10'h200;
  localparam logic [COL_W-1:0] SPARE_X16 = 10'h100;
  localparam int HALF_BIT = 8; // column bit selected by the read command
  localparam logic [ROW_W-1:0] BLK_MASK = ~16'(PAGES_PER_BLK - 1);
  localparam logic [1:0] ADDR_CYC_PAGE = 2'h3;
  localparam logic [1:0] ADDR_CYC_ERASE = 2'h2;
  localparam logic [1:0] ADDR_CYC_ID = 2'h1;
  //----------------------------------------------------------------
  // operations and states
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_IDENT = 3'h1, OP_STATUS = 3'h2, OP_RESET = 3'h3,
    OP_PROG = 3'h4, OP_COPY = 3'h5, OP_ERASE = 3'h6
  } ncai_op_t;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_HOLD = 8'h02, S_CMD = 8'h04, S_ADDR = 8'h08,
    S_WDATA = 8'h10, S_CMD2 = 8'h20, S_BUSY = 8'h40, S_READ = 8'h80
  } ncai_state_t;
endpackage

// *** core/ncai_ctrl.sv ***
// host controller driving a nand flash over its multiplexed i/o pins
// assumes the bench resolves the i/o wires from io_oe_n and pulls ready/busy up
//
// Notes on behaviour
// - a page address goes in three byte cycles: column, low row, high row.
// - on x16 the upper eight lines stay low in address cycles.
// - values are written by a low write pulse with select low, taken on rise.
// - command latch marks commands, address latch addresses, neither means data.
// - read and program use three address cycles, erase two row cycles.
// - program is 80h, address and data, then 10h to start.
// - copy-back uses 00h then 8Ah; erase uses 60h then D0h.
`timescale 1ns/1ns

module ncai_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  // handshakes and occupancy
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  // pointers, count and registered ready
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else if (clk_en) begin
      wp_r <= push ? AW'(wp_r + 1'b1) : wp_r;
      rp_r <= pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt < (AW+1)'(DEPTH));
    end
  end

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

module ncai_ctrl import ncai_pkg::*; #(
  parameter bit X16 = 1'b0,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [ROW_W-1:0] cmd_row,
  input wire logic [ROW_W-1:0] cmd_dst_row,
  input wire logic [COL_W-1:0] cmd_col,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic spare_en,
  output logic done,
  // program data in
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  // read data out
  output logic rd_valid,
  output logic [15:0] rd_data,
  // flash pins
  output logic [15:0] io_out,
  output logic io_oe_n,
  input wire logic [15:0] io_in,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic output_strobe_n,
  output logic wp_n,
  output logic spare_sel_n,
  input wire logic rb_n
);
  //----------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------
  ncai_state_t state_r;
  ncai_op_t op_r;
  logic [ROW_W-1:0] row_r, dst_r;
  logic [COL_W-1:0] col_r;
  logic [LEN_W-1:0] len_r;
  logic [1:0] acnt_r;
  logic [3:0] tcnt_r;
  logic ph_r, second_r, rb_ok_r;
  logic [2:0] rb_s;
  logic [15:0] io_s1, io_s2, io_s3;
  logic f_valid, f_ready, f_ready_r;
  logic [15:0] f_data;
  logic fifo_in_ready;

  //----------------------------------------------------------------
  // decode
  //----------------------------------------------------------------
  wire [COL_W-1:0] spare_base = X16 ? SPARE_X16 : SPARE_X8;
  wire in_spare = (col_r >= spare_base);
  wire [COL_W-1:0] col_off = in_spare ? COL_W'(col_r - spare_base) : col_r;
  wire hi_half = !X16 && col_r[HALF_BIT];
  wire [7:0] rd_cmd = in_spare ? CMD_READ_SPARE : (hi_half ? CMD_READ_HI : CMD_READ_LO);
  wire [7:0] cmd1 = (op_r == OP_READ) ? rd_cmd :
                    (op_r == OP_IDENT) ? CMD_IDENT :
                    (op_r == OP_STATUS) ? CMD_STATUS :
                    (op_r == OP_RESET) ? CMD_RESET :
                    (op_r == OP_PROG) ? CMD_PROG :
                    (op_r == OP_COPY) ? CMD_COPY : CMD_ERASE;
  wire [7:0] cmd2 = (op_r == OP_PROG) ? CMD_PROG_GO :
                    (op_r == OP_COPY) ? CMD_COPY_GO : CMD_ERASE_GO;
  wire [1:0] addr_need = (op_r == OP_IDENT) ? ADDR_CYC_ID :
                         (op_r == OP_ERASE) ? ADDR_CYC_ERASE : ADDR_CYC_PAGE;
  wire [ROW_W-1:0] cur_row = second_r ? dst_r : row_r;
  wire [ROW_W-1:0] use_row = (op_r == OP_ERASE) ? (cur_row & BLK_MASK) : cur_row;
  wire [1:0] aidx = (op_r == OP_ERASE) ? 2'(acnt_r + 1'b1) : acnt_r;
  wire [7:0] abyte = (op_r == OP_IDENT) ? ADDR_ZERO :
                     (aidx == 2'h0) ? col_off[7:0] :
                     (aidx == 2'h1) ? use_row[7:0] : use_row[15:8];
  wire allowed_busy = (op_r == OP_RESET) || (op_r == OP_STATUS);
  wire needs_wp = (op_r == OP_PROG) || (op_r == OP_COPY) || (op_r == OP_ERASE);
  wire [15:0] rd_word = X16 ? io_s3 : {8'h00, io_s3[7:0]};
  wire wr_state = (state_r == S_CMD) || (state_r == S_ADDR) || (state_r == S_CMD2);
  wire [7:0] wr_byte = (state_r == S_ADDR) ? abyte : ((state_r == S_CMD2) ? cmd2 : cmd1);
  assign f_ready = f_ready_r;

  //----------------------------------------------------------------
  // program data buffer
  //----------------------------------------------------------------
  ncai_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .in_valid(wr_valid), .in_ready(fifo_in_ready), .in_data(wr_data),
    .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data)
  );
  assign wr_ready = fifo_in_ready;

  //----------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------
  // ready/busy passes three flops, a change counts once the last two agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rb_s <= 3'h0;
      rb_ok_r <= 1'b0;
      io_s1 <= 16'h0000;
      io_s2 <= 16'h0000;
      io_s3 <= 16'h0000;
    end else if (clk_en) begin
      rb_s <= {rb_s[1:0], rb_n};
      rb_ok_r <= (rb_s[1] == rb_s[2]) ? rb_s[2] : rb_ok_r;
      io_s1 <= io_in;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  //----------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------
  // each write cycle: strobe low one clock, high one clock, value taken on the rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE; op_r <= OP_READ; row_r <= '0; dst_r <= '0; col_r <= '0;
      len_r <= '0; acnt_r <= '0; tcnt_r <= '0; ph_r <= 1'b0; second_r <= 1'b0;
      f_ready_r <= 1'b0; cmd_ready <= 1'b0; done <= 1'b0; rd_valid <= 1'b0;
      rd_data <= 16'h0000; io_out <= 16'h0000; io_oe_n <= 1'b1; cle <= 1'b0;
      ale <= 1'b0; ce_n <= 1'b1; we_n <= 1'b1; output_strobe_n <= 1'b1; wp_n <= 1'b0;
      spare_sel_n <= 1'b1;
    end else if (clk_en) begin
      done <= 1'b0;
      rd_valid <= 1'b0;
      f_ready_r <= 1'b0;
      spare_sel_n <= !spare_en;
      case (state_r)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          ce_n <= 1'b1;
          wp_n <= 1'b0;
          io_oe_n <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_r <= ncai_op_t'(cmd_op);
            row_r <= cmd_row; dst_r <= cmd_dst_row; col_r <= cmd_col; len_r <= cmd_len;
            second_r <= 1'b0;
            ce_n <= 1'b0;
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          wp_n <= needs_wp;
          ph_r <= 1'b0;
          if (rb_ok_r || allowed_busy) state_r <= S_CMD;
        end
        S_CMD, S_ADDR, S_CMD2: begin
          if (!ph_r) begin
            io_out <= {8'h00, wr_byte};
            io_oe_n <= 1'b0;
            cle <= (state_r != S_ADDR);
            ale <= (state_r == S_ADDR);
            we_n <= 1'b0;
            ph_r <= 1'b1;
          end else begin
            we_n <= 1'b1;
            ph_r <= 1'b0;
            acnt_r <= (state_r == S_ADDR) ? 2'(acnt_r + 1'b1) : 2'h0;
            if (state_r == S_CMD) begin
              state_r <= (op_r == OP_RESET) ? S_BUSY :
                         (op_r == OP_STATUS) ? S_READ : S_ADDR;
              tcnt_r <= 4'(WB_CYC);
              if (op_r == OP_STATUS) len_r <= LEN_W'(1);
            end else if (state_r == S_CMD2) begin
              state_r <= (op_r == OP_COPY) ? S_ADDR : S_BUSY;
              tcnt_r <= 4'(WB_CYC);
            end else if (2'(acnt_r + 1'b1) == addr_need) begin
              tcnt_r <= 4'(WB_CYC);
              state_r <= (op_r == OP_IDENT) ? S_READ :
                         (op_r == OP_PROG) ? S_WDATA :
                         (op_r == OP_ERASE) ? S_CMD2 : S_BUSY;
            end
          end
        end
        S_WDATA: begin
          cle <= 1'b0;
          ale <= 1'b0;
          if (!ph_r) begin
            if (len_r == '0) begin
              state_r <= S_CMD2;
            end else if (f_valid && !f_ready_r) begin
              io_out <= X16 ? f_data : {8'h00, f_data[7:0]};
              f_ready_r <= 1'b1;
              we_n <= 1'b0;
              ph_r <= 1'b1;
            end
          end else begin
            we_n <= 1'b1;
            len_r <= LEN_W'(len_r - 1'b1);
            ph_r <= 1'b0;
          end
        end
        S_BUSY: begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe_n <= 1'b1;
          if (tcnt_r != '0) begin
            tcnt_r <= 4'(tcnt_r - 1'b1);
          end else if (rb_ok_r) begin
            ph_r <= 1'b0;
            if (op_r == OP_READ) begin
              state_r <= S_READ;
            end else if (op_r == OP_COPY && !second_r) begin
              second_r <= 1'b1;
              state_r <= S_CMD2;
            end else begin
              done <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_READ: begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe_n <= 1'b1;
          if (!ph_r) begin
            if (len_r == '0) begin
              done <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              output_strobe_n <= 1'b0;
              tcnt_r <= 4'(RD_LOW_CYC);
              ph_r <= 1'b1;
            end
          end else if (tcnt_r != '0) begin
            tcnt_r <= 4'(tcnt_r - 1'b1);
          end else if (!output_strobe_n) begin
            output_strobe_n <= 1'b1;
            rd_data <= rd_word;
            rd_valid <= 1'b1;
            len_r <= LEN_W'(len_r - 1'b1);
          end else begin
            ph_r <= 1'b0;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  logic [2:0] acount_h;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) acount_h <= 3'h0;
    else if (clk_en && we_n == 1'b0 && cle) acount_h <= 3'h0;
    else if (clk_en && we_n == 1'b0 && ale && ph_r) acount_h <= 3'(acount_h + 1'b1);
  end
  property p_we_pulse;
    @(posedge clock) disable iff (!rst_b) $fell(we_n) && clk_en |-> !ce_n ##1 !clk_en || we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe wrong");
  property p_latch_excl;
    @(posedge clock) disable iff (!rst_b) !we_n |-> !(cle && ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_upper_low;
    @(posedge clock) disable iff (!rst_b) (cle || ale) && !we_n |-> io_out[15:8] == 8'h00;
  endproperty
  a_upper_low: assert property (p_upper_low) else $error("upper lines not low");
  property p_addr_max;
    @(posedge clock) disable iff (!rst_b) acount_h <= 3'h3;
  endproperty
  a_addr_max: assert property (p_addr_max) else $error("too many address cycles");
  property p_erase_two;
    @(posedge clock) disable iff (!rst_b)
      !we_n && cle && io_out[7:0] == CMD_ERASE_GO && op_r == OP_ERASE |-> acount_h == 3'h2;
  endproperty
  a_erase_two: assert property (p_erase_two) else $error("erase address count");
  property p_busy_gate;
    @(posedge clock) disable iff (!rst_b)
      state_r == S_HOLD && !rb_ok_r && !allowed_busy && clk_en |=> state_r == S_HOLD;
  endproperty
  a_busy_gate: assert property (p_busy_gate) else $error("command sent while busy");
  property p_no_hi_x16;
    @(posedge clock) disable iff (!rst_b) !we_n && cle |-> !(X16 && io_out[7:0] == CMD_READ_HI);
  endproperty
  a_no_hi_x16: assert property (p_no_hi_x16) else $error("01h on x16");
  property p_wp_high;
    @(posedge clock) disable iff (!rst_b)
      !we_n && cle && (io_out[7:0] == CMD_PROG || io_out[7:0] == CMD_ERASE) |-> wp_n;
  endproperty
  a_wp_high: assert property (p_wp_high) else $error("protect low at program");
  property p_strobe_data;
    @(posedge clock) disable iff (!rst_b)
      $rose(output_strobe_n) |-> rd_valid && $past(output_strobe_n, 2) == 1'b0;
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("read word not taken");
  property p_busy_wait;
    @(posedge clock) disable iff (!rst_b)
      state_r == S_BUSY && !rb_ok_r && clk_en |=> state_r == S_BUSY;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("left busy early");
  property p_erase_blk;
    @(posedge clock) disable iff (!rst_b)
      state_r == S_ADDR && op_r == OP_ERASE && acnt_r == 2'h0 && !we_n |-> io_out[4:0] == 5'h00;
  endproperty
  a_erase_blk: assert property (p_erase_blk) else $error("erase not block aligned");
  c_prog: cover property (@(posedge clock) !we_n && cle && io_out[7:0] == CMD_PROG_GO);
  c_erase: cover property (@(posedge clock) !we_n && cle && io_out[7:0] == CMD_ERASE_GO);
  c_read: cover property (@(posedge clock) rd_valid && op_r == OP_READ);
  c_stat_busy: cover property (@(posedge clock) state_r == S_CMD && !rb_ok_r && allowed_busy);
endmodule

// *** tb/ncai_flash_model.sv ***
// behavioural nand flash answering the host controller's pins, x8 or x16
// assumes the bench resolves the shared i/o wires and pulls ready/busy up
`timescale 1ns/1ns
module ncai_flash_model import ncai_pkg::*; #(
  parameter bit X16 = 1'b0,
  parameter int BUSY_NS = 2000,
  parameter logic [15:0] ID_WORD = 16'h005A, // arbitrary identifier value
  parameter logic [15:0] STAT_WORD = 16'h00C0
) (
  // strobes
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic wp_n,
  input wire logic spare_sel_n,
  // i/o and ready/busy
  input wire logic [15:0] io,
  output logic [15:0] dout,
  output logic drv,
  output logic busy
);
  //----------------------------------------------------------------
  // page store and command state
  //----------------------------------------------------------------
  logic [15:0] mem [int];
  logic [15:0] pbuf [int];
  logic [9:0] cyc_log [$];
  logic [7:0] cmd = 8'hFF;
  logic [15:0] row = 16'h0000;
  logic [15:0] srow = 16'h0000;
  int col = 0;
  int acnt = 0;
  initial busy = 1'b0;
  initial dout = 16'h0000;
  // drives only while strobed; select going high while busy changes nothing
  assign drv = !ce_n && !output_strobe_n;
  function automatic int key(input logic [15:0] r, input int c);
    return int'(r) * 1024 + c;
  endfunction
  // ready/busy held low for the internal operation
  task automatic go_busy(input int ns);
    busy = 1'b1;
    #(ns);
    busy = 1'b0;
  endtask
  // every write strobe rise with select low takes one byte or word
  always @(posedge we_n) begin
    if (!ce_n) begin
      cyc_log.push_back({cle, ale, io[7:0]});
      if (cle && (!busy || io[7:0] == CMD_RESET || io[7:0] == CMD_STATUS)) begin
        cmd = io[7:0];
        acnt = 0;
        if (cmd == CMD_PROG_GO && wp_n) begin
          foreach (pbuf[k]) mem[key(row, k)] = pbuf[k];
          fork go_busy(BUSY_NS); join_none
        end
        if (cmd == CMD_ERASE_GO && wp_n) begin
          for (int k = key(row & BLK_MASK, 0); k < key(row & BLK_MASK, 0) + 32768; k++)
            if (mem.exists(k)) mem.delete(k);
          fork go_busy(BUSY_NS); join_none
        end
        if (cmd == CMD_PROG) pbuf.delete();
        if (cmd == CMD_RESET) fork go_busy(500); join_none
      end else if (ale && cmd == CMD_ERASE) begin
        if (acnt == 0) row[7:0] = io[7:0];
        if (acnt == 1) row[15:8] = io[7:0];
        acnt++;
      end else if (ale) begin
        if (acnt == 0 && cmd == CMD_READ_SPARE) col = (X16 ? 256 : 512) + int'(io[3:0]);
        else if (acnt == 0) col = int'(io[7:0]) + ((cmd == CMD_READ_HI && !X16) ? 256 : 0);
        if (acnt == 1) row[7:0] = io[7:0];
        if (acnt == 2) begin
          row[15:8] = io[7:0];
          if (cmd == CMD_COPY_GO && wp_n) begin
            foreach (pbuf[k]) mem[key(row, k)] = pbuf[k];
          end else begin // page read loads the data register
            srow = row;
            pbuf.delete();
            for (int c = 0; c < PAGE_X8; c++) if (mem.exists(key(row, c))) pbuf[c] = mem[key(row, c)];
          end
          fork go_busy(BUSY_NS); join_none
        end
        acnt++;
      end else if (cmd == CMD_PROG) begin
        pbuf[col] = X16 ? io : {8'h00, io[7:0]};
        col++;
      end
    end
  end
  // each read strobe fall puts out the next word; outside ident and status it also steps the column
  always @(negedge output_strobe_n) begin
    if (!ce_n) begin
      if (cmd == CMD_IDENT) dout = ID_WORD;
      else if (cmd == CMD_STATUS) dout = STAT_WORD;
      else begin
        dout = mem.exists(key(srow, col)) ? mem[key(srow, col)] : 16'hFFFF;
        col++;
        if (col == (X16 ? 256 : 512) && spare_sel_n) begin
          col = 0;
          srow++;
        end
      end
    end
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the nand host controller, x8 organization
// assumes the flash model beside it; ready/busy is pulled up here
`timescale 1ns/1ns
module tb import ncai_pkg::*;;
  //----------------------------------------------------------------
  // stimulus, wires and instances
  //----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [15:0] cmd_row = 16'h0000;
  logic [15:0] cmd_dst_row = 16'h0000;
  logic [9:0] cmd_col = 10'h000;
  logic [9:0] cmd_len = 10'h000;
  logic spare_en = 1'b0;
  logic clk_en = 1'b1;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic force_busy = 1'b0;
  logic [15:0] float_v = 16'h5A5A;
  logic cmd_ready, done, wr_ready, rd_valid, io_oe_n, cle, ale, ce_n, we_n, output_strobe_n, wp_n;
  logic spare_sel_n, drv, busy;
  logic [15:0] rd_data, io_out, dout, io_bus;
  logic [15:0] rdq [$];
  logic [9:0] exp_q [$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // released lines toggle so a stale value never passes
  assign io_bus = !io_oe_n ? io_out : (drv ? dout : float_v);
  ncai_ctrl ncai_ctrl_i (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_row(cmd_row), .cmd_dst_row(cmd_dst_row),
    .cmd_col(cmd_col), .cmd_len(cmd_len), .spare_en(spare_en), .done(done),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_bus), .cle(cle),
    .ale(ale), .ce_n(ce_n), .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n),
    .spare_sel_n(spare_sel_n), .rb_n(!(busy || force_busy)));
  ncai_flash_model ncai_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .output_strobe_n(output_strobe_n), .wp_n(wp_n), .spare_sel_n(spare_sel_n),
    .io(io_bus), .dout(dout), .drv(drv), .busy(busy));
  // clock, floating pattern, read capture and hang limit
  always #50 clock = ~clock;
  always @(posedge clock) begin
    float_v <= ~float_v;
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  //----------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic void ex(input logic [1:0] k, input logic [7:0] v);
    exp_q.push_back({k, v});
  endfunction
  // pin cycles seen by the flash against the expected list
  task automatic chk_log();
    chk("cycle count", 16'(exp_q.size()), 16'(ncai_flash_model_i.cyc_log.size()));
    foreach (exp_q[i])
      if (i < ncai_flash_model_i.cyc_log.size())
        chk("pin cycle", 16'(exp_q[i]), 16'(ncai_flash_model_i.cyc_log[i]));
    exp_q.delete();
    ncai_flash_model_i.cyc_log.delete();
  endtask
  task automatic run(input logic [2:0] op, input logic [15:0] row, input logic [15:0] dst,
      input logic [9:0] col, input logic [9:0] len);
    int n;
    rdq.delete();
    cmd_op <= op;
    cmd_row <= row;
    cmd_dst_row <= dst;
    cmd_col <= col;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    @(posedge clock);
    while (cmd_ready !== 1'b1) @(posedge clock);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) chk("done", 16'h0001, 16'h0000);
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //----------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------
  task automatic t_fill_prog();
    int n;
    n = 0;
    wr_data <= 16'h0030;
    wr_valid <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      if (wr_ready === 1'b1 && clk_en) n++;
      wr_data <= 16'h0030 + 16'(n);
      // four frozen edges mid-fill must neither push nor lose a word
      clk_en <= (i < 9 || i > 12);
    end
    wr_valid <= 1'b0;
    chk("fifo words", 16'h0020, 16'(n));
    chk("write protect idle", 16'h0000, 16'(wp_n));
    run(OP_PROG, 16'h0041, 16'h0000, 10'h000, 10'h020);
    ex(2'h2, 8'h80); ex(2'h1, 8'h00); ex(2'h1, 8'h41); ex(2'h1, 8'h00);
    for (int i = 0; i < 32; i++) ex(2'h0, 8'h30 + 8'(i));
    ex(2'h2, 8'h10);
    chk_log();
    chk("fifo ready after drain", 16'h0001, 16'(wr_ready));
  endtask
  task automatic t_reads();
    run(OP_READ, 16'h0041, 16'h0000, 10'h000, 10'h004);
    ex(2'h2, 8'h00); ex(2'h1, 8'h00); ex(2'h1, 8'h41); ex(2'h1, 8'h00);
    chk_log();
    chk("read words", 16'h0004, 16'(rdq.size()));
    for (int i = 0; i < 4; i++) chk("read word", 16'h0030 + 16'(i), rdq[i]);
    run(OP_READ, 16'h0041, 16'h0000, 10'h105, 10'h001);
    ex(2'h2, 8'h01); ex(2'h1, 8'h05); ex(2'h1, 8'h41); ex(2'h1, 8'h00);
    chk_log();
    spare_en <= 1'b1;
    run(OP_READ, 16'h0041, 16'h0000, 10'h203, 10'h001);
    chk("spare select", 16'h0000, 16'(spare_sel_n));
    ex(2'h2, 8'h50); ex(2'h1, 8'h03); ex(2'h1, 8'h41); ex(2'h1, 8'h00);
    chk_log();
    chk("spare word", 16'h00FF, rdq[0]);
    spare_en <= 1'b0;
  endtask
  task automatic t_copy_erase();
    run(OP_COPY, 16'h0041, 16'h0100, 10'h000, 10'h000);
    ex(2'h2, 8'h00); ex(2'h1, 8'h00); ex(2'h1, 8'h41); ex(2'h1, 8'h00);
    ex(2'h2, 8'h8A); ex(2'h1, 8'h00); ex(2'h1, 8'h00); ex(2'h1, 8'h01);
    chk_log();
    run(OP_ERASE, 16'h0045, 16'h0000, 10'h000, 10'h000);
    ex(2'h2, 8'h60); ex(2'h1, 8'h40); ex(2'h1, 8'h00); ex(2'h2, 8'hD0);
    chk_log();
    run(OP_READ, 16'h0041, 16'h0000, 10'h000, 10'h001);
    chk("erased word", 16'h00FF, rdq[0]);
    run(OP_READ, 16'h0100, 16'h0000, 10'h001, 10'h001);
    chk("copied word", 16'h0031, rdq[0]);
    ncai_flash_model_i.cyc_log.delete();
  endtask
  task automatic t_id_status_busy();
    run(OP_IDENT, 16'h0000, 16'h0000, 10'h000, 10'h001);
    ex(2'h2, 8'h90); ex(2'h1, 8'h00);
    chk_log();
    chk("ident word", 16'h005A, rdq[0]);
    run(OP_STATUS, 16'h0000, 16'h0000, 10'h000, 10'h001);
    ex(2'h2, 8'h70);
    chk_log();
    chk("status word", 16'h00C0, rdq[0]);
    force_busy <= 1'b1;
    // let the ready/busy filter see busy before asking
    repeat (5) @(posedge clock);
    fork run(OP_READ, 16'h0041, 16'h0000, 10'h000, 10'h001); join_none
    repeat (40) @(posedge clock);
    chk("cycles while busy", 16'h0000, 16'(ncai_flash_model_i.cyc_log.size()));
    force_busy <= 1'b0;
    wait fork;
    ncai_flash_model_i.cyc_log.delete();
    force_busy <= 1'b1;
    repeat (5) @(posedge clock);
    fork run(OP_RESET, 16'h0000, 16'h0000, 10'h000, 10'h000); join_none
    repeat (40) @(posedge clock);
    ex(2'h2, 8'hFF);
    chk_log();
    force_busy <= 1'b0;
    wait fork;
  endtask
  // reset, settle the ready/busy filter, then the scenarios
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_fill_prog();
    t_reads();
    t_copy_erase();
    t_id_status_busy();
    results();
  end
endmodule
